// *** reset_and_processor_mode_setup.sv ***
// reset sequencing, vector fetch and mode-dependent pin control
module reset_and_processor_mode_setup
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        mode_select_pin,
	input  wire logic        byte_pin,
	input  wire logic        wdt_reset_select,
	input  wire logic        wdt_underflow,
	input  wire logic        mode_wr,
	input  wire logic [1:0]  mode_wdata,
	input  wire logic        hold_req,
	input  wire logic        ready_in,
	output logic      [1:0]  processor_mode,
	output logic             cpu_run,
	output logic             cpu_init,
	output logic      [19:0] bus_addr,
	output logic             bus_addr_oe,
	output logic             chip_select_zero,
	output logic             wr_n,
	output logic             rd_n,
	output logic             ale,
	output logic             high_byte_enable,
	output logic             bus_ctrl_oe,
	output logic             hold_ack_out,
	output logic             ready_seen,
	output logic      [10:0] port_input_force,
	output logic      [2:0]  p4_pullup,
	output logic      [4:0]  space_enable,
	output logic             bclk_out
);
	rst_mode_pkg::seq_state_type state_q;
	logic [1:0]  processor_mode_field;
	logic        wdt_rst;
	logic        in_reset;
	logic [7:0]  wait_q;
	logic        fetch_start;
	logic        fetch_busy;
	logic        fetch_done;
	logic [19:0] fetch_addr;
	logic        fetch_rd;
	logic        micro;
	logic        ext_bus;
	logic        bclk_q;

	assign wdt_rst     = wdt_reset_select && wdt_underflow;
	assign in_reset    = sys_rst || wdt_rst;
	assign micro       = processor_mode_field == rst_mode_pkg::MODE_MICRO;
	assign ext_bus     = processor_mode_field != rst_mode_pkg::MODE_SINGLE;
	assign fetch_start = state_q == rst_mode_pkg::ST_FETCH;

	mode_reg u_mode
	(
		.clk_sys              (clk_sys),
		.sys_rst              (sys_rst),
		.mode_select_pin      (mode_select_pin),
		.mode_wr              (mode_wr && state_q == rst_mode_pkg::ST_RUN),
		.mode_wdata           (mode_wdata),
		.processor_mode_field (processor_mode_field)
	);

	vec_fetch u_fetch
	(
		.clk_sys   (clk_sys),
		.sys_rst   (in_reset),
		.start     (fetch_start),
		.byte_mode (byte_pin),
		.busy      (fetch_busy),
		.done      (fetch_done),
		.addr      (fetch_addr),
		.rd_strobe (fetch_rd)
	);

	// bus clock derived from clk_sys, half rate
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			bclk_q <= 1'b0;
		else
			bclk_q <= ~bclk_q;
	end

	always_ff @(posedge clk_sys)
	begin
		if (in_reset)
		begin
			state_q <= rst_mode_pkg::ST_RESET;
			wait_q  <= 8'h0;
		end
		else
		begin
			case (state_q)
				rst_mode_pkg::ST_RESET:
				begin
					state_q <= rst_mode_pkg::ST_WAIT;
					wait_q  <= 8'h0;
				end
				rst_mode_pkg::ST_WAIT:
				begin
					wait_q <= wait_q + 8'h1;
					if (wait_q == rst_mode_pkg::VEC_WAIT_CNT - 8'h1)
						state_q <= rst_mode_pkg::ST_FETCH;
				end
				rst_mode_pkg::ST_FETCH:
					state_q <= rst_mode_pkg::ST_IDLE;
				rst_mode_pkg::ST_IDLE:
				begin
					if (fetch_done)
						state_q <= rst_mode_pkg::ST_RUN;
				end
				rst_mode_pkg::ST_RUN:
					state_q <= rst_mode_pkg::ST_RUN;
				default:
					state_q <= rst_mode_pkg::ST_RESET;
			endcase
		end
	end

	// cpu status outputs
	always_ff @(posedge clk_sys)
	begin
		processor_mode <= processor_mode_field;
		cpu_run        <= !in_reset && state_q == rst_mode_pkg::ST_RUN;
		cpu_init       <= in_reset || state_q == rst_mode_pkg::ST_RESET;
		bclk_out       <= sys_rst ? 1'b0 : bclk_q;
		// only the two external-capable modes reach outside; rom blocked in micro
		space_enable   <= in_reset ? 5'h0 : rst_mode_pkg::space_of(processor_mode_field);
	end

	// bus pins: reset values held throughout reset, mode use after release
	always_ff @(posedge clk_sys)
	begin
		if (in_reset)
		begin
			chip_select_zero <= 1'b1;
			wr_n             <= 1'b1;
			rd_n             <= 1'b1;
			ale              <= 1'b0;
			high_byte_enable <= 1'b0; // left undefined by the pin table; zero is one legal value
			bus_addr         <= 20'h0;
			bus_addr_oe      <= micro;
			bus_ctrl_oe      <= micro;
		end
		else
		begin
			chip_select_zero <= !(ext_bus && fetch_busy && micro);
			rd_n             <= !(fetch_rd && micro);
			wr_n             <= 1'b1;
			ale              <= fetch_rd && micro;
			high_byte_enable <= !byte_pin && fetch_busy && micro;
			bus_addr         <= micro ? fetch_addr : 20'h0;
			bus_addr_oe      <= ext_bus;
			bus_ctrl_oe      <= ext_bus;
		end
	end

	// hold handshake and ready sampling
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst && !micro)
		begin
			hold_ack_out <= 1'b0;
			ready_seen   <= 1'b0;
		end
		else
		begin
			hold_ack_out <= (micro || ext_bus) && hold_req;
			ready_seen   <= ready_in;
		end
	end

	// port direction forcing: bit n forces port n to input
	always_ff @(posedge clk_sys)
	begin
		if (in_reset)
		begin
			port_input_force <= micro ? 11'h7c0 : 11'h7ff;
			p4_pullup        <= micro ? 3'h7 : 3'h0;
		end
		else
		begin
			port_input_force <= ext_bus ? 11'h7c0 : 11'h000;
			p4_pullup        <= 3'h0;
		end
	end

	a_cs_high_reset: assert property (@(posedge clk_sys) in_reset |=> chip_select_zero && wr_n && rd_n && !ale)
		else $error("bus strobes not idle in reset");
	a_ports_input_reset: assert property (@(posedge clk_sys) (in_reset && !micro) |=> port_input_force == 11'h7ff)
		else $error("ports not inputs in single-chip reset");
	a_high_ports_input: assert property (@(posedge clk_sys) in_reset |=> port_input_force[10:6] == 5'h1f)
		else $error("ports six to ten not inputs");
	a_pullup_micro: assert property (@(posedge clk_sys) (in_reset && micro) |=> p4_pullup == 3'h7)
		else $error("port four pull-ups missing");
	a_hold_follow: assert property (@(posedge clk_sys) (sys_rst && micro) |=> hold_ack_out == $past(hold_req))
		else $error("hold ack does not follow request");
	a_wait_count: assert property (@(posedge clk_sys) disable iff (in_reset)
		$rose(state_q == rst_mode_pkg::ST_WAIT) |-> (state_q == rst_mode_pkg::ST_WAIT)[*8])
		else $error("vector wait too short");
	a_mode_legal: assert property (@(posedge clk_sys) disable iff (sys_rst)
		processor_mode_field != rst_mode_pkg::MODE_BAD)
		else $error("forbidden mode code");
	a_mode_wdt_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wdt_rst |=> processor_mode_field == $past(processor_mode_field))
		else $error("mode lost over watchdog reset");
	a_strap_mode: assert property (@(posedge clk_sys) sys_rst |=> processor_mode_field == ($past(mode_select_pin) ? 2'h3 : 2'h0))
		else $error("mode strap wrong");
	a_rom_blocked: assert property (@(posedge clk_sys) (!in_reset && micro) |=> !space_enable[2])
		else $error("internal rom reachable in micro mode");
	a_vec_start: assert property (@(posedge clk_sys) disable iff (in_reset)
		fetch_start |=> fetch_addr == rst_mode_pkg::VEC_ADDR)
		else $error("vector fetch not from top address");
	a_wdt_restart: assert property (@(posedge clk_sys) wdt_rst |=> state_q == rst_mode_pkg::ST_RESET)
		else $error("watchdog did not restart sequence");
endmodule

// *** rst_mode_pkg.sv ***
// constants and types for the reset and processor-mode block
package rst_mode_pkg;
	localparam logic [1:0]  MODE_SINGLE   = 2'h0;
	localparam logic [1:0]  MODE_EXPAND   = 2'h1;
	localparam logic [1:0]  MODE_BAD      = 2'h2;
	localparam logic [1:0]  MODE_MICRO    = 2'h3;
	localparam logic [19:0] VEC_ADDR      = 20'hffffc;
	localparam int          VEC_WAIT_BCLK = 28;
	localparam int          BCLK_DIV      = 2;
	localparam logic [7:0]  VEC_WAIT_CNT  = 8'(VEC_WAIT_BCLK * BCLK_DIV);
	localparam logic [1:0]  BYTE_READS    = 2'h3;
	localparam logic [1:0]  WORD_READS    = 2'h2;

	typedef enum logic [4:0]
	{
		ST_RESET = 5'b00001,
		ST_WAIT  = 5'b00010,
		ST_FETCH = 5'b00100,
		ST_RUN   = 5'b01000,
		ST_IDLE  = 5'b10000
	} seq_state_type;

	// access space: sfr, ram, rom, display memories, external
	function automatic logic [4:0] space_of(input logic [1:0] mode);
		case (mode)
			MODE_SINGLE: space_of = 5'h0f;
			MODE_EXPAND: space_of = 5'h1f;
			MODE_MICRO:  space_of = 5'h1b;
			default:     space_of = 5'h0f;
		endcase
	endfunction
endpackage

// *** mode_reg.sv ***
// processor mode field: strap at hardware reset, kept over watchdog reset
module mode_reg
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       mode_select_pin,
	input  wire logic       mode_wr,
	input  wire logic [1:0] mode_wdata,
	output logic      [1:0] processor_mode_field
);
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			processor_mode_field <= mode_select_pin ? rst_mode_pkg::MODE_MICRO : rst_mode_pkg::MODE_SINGLE;
		else if (mode_wr && mode_wdata != rst_mode_pkg::MODE_BAD)
			processor_mode_field <= mode_wdata;
	end
	// watchdog reset does not enter here, so the mode survives it
endmodule

// *** vec_fetch.sv ***
// reset vector fetch: byte or word reads from the top of memory
module vec_fetch
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        start,
	input  wire logic        byte_mode,
	output logic             busy,
	output logic             done,
	output logic      [19:0] addr,
	output logic             rd_strobe
);
	logic [1:0] cnt_q;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			busy      <= 1'b0;
			done      <= 1'b0;
			addr      <= rst_mode_pkg::VEC_ADDR;
			rd_strobe <= 1'b0;
			cnt_q     <= 2'h0;
		end
		else
		begin
			done      <= 1'b0;
			rd_strobe <= 1'b0;
			if (start && !busy)
			begin
				busy      <= 1'b1;
				addr      <= rst_mode_pkg::VEC_ADDR;
				rd_strobe <= 1'b1;
				cnt_q     <= 2'h1;
			end
			else if (busy)
			begin
				if (cnt_q == (byte_mode ? rst_mode_pkg::BYTE_READS : rst_mode_pkg::WORD_READS))
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				else
				begin
					// byte reads step by one, word reads by two
					addr      <= addr + (byte_mode ? 20'h1 : 20'h2);
					rd_strobe <= 1'b1;
					cnt_q     <= cnt_q + 2'h1;
				end
			end
		end
	end
endmodule

// *** ext_bus_model.sv ***
// far-side bus model: logs vector reads, drives hold request and ready
module ext_bus_model
(
	input  wire logic        clk_sys,
	input  wire logic        rd_n,
	input  wire logic [19:0] bus_addr,
	input  wire logic        hold_in,
	input  wire logic        slow,
	output logic             hold_req,
	output logic             ready_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [19:0] seen[$];
	logic [1:0]  wait_q = 2'h0;
	logic        hold_q = 1'b0;
	logic        rdy_q  = 1'b1;
	// one driver per output: the registers carry the start-up values
	assign hold_req = hold_q;
	assign ready_in = rdy_q;
	always @(posedge clk_sys)
	begin
		hold_q <= hold_in;
		// read strobe is low one cycle per access, so one entry per read
		if (rd_n === 1'b0)
			seen.push_back(bus_addr);
		wait_q <= wait_q + 2'h1;
		// slow device: ready only one cycle in four
		rdy_q <= !slow || (wait_q == 2'h3);
	end
endmodule

// *** reset_and_processor_mode_setup_tb.sv ***
// self-checking bench for reset sequencing and processor modes
module reset_and_processor_mode_setup_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0, sys_rst = 1'b1, mode_select_pin = 1'b0, byte_pin = 1'b0;
	logic        wdt_reset_select = 1'b0, wdt_underflow = 1'b0, mode_wr = 1'b0, hold_in = 1'b0, slow = 1'b0;
	logic [1:0]  mode_wdata = 2'h0, exp_m, w;
	logic        hold_req, ready_in, cpu_run, cpu_init, chip_select_zero, wr_n, rd_n, ale, bus_ctrl_oe, hold_ack_out;
	logic [1:0]  processor_mode;
	logic [19:0] bus_addr;
	logic [10:0] port_input_force;
	logic [2:0]  p4_pullup;
	logic [4:0]  space_enable;
	logic        bus_addr_oe, high_byte_enable, ready_seen, bclk_out, rdy_prev = 1'b0;
	int          seed = 24720, failures = 0, tests_run = 0;

	always #4 clk_sys = ~clk_sys;

	reset_and_processor_mode_setup i_dut (.clk_sys, .sys_rst, .mode_select_pin, .byte_pin, .wdt_reset_select,
		.wdt_underflow, .mode_wr, .mode_wdata, .hold_req, .ready_in, .processor_mode, .cpu_run, .cpu_init,
		.bus_addr, .bus_addr_oe, .chip_select_zero, .wr_n, .rd_n, .ale, .high_byte_enable, .bus_ctrl_oe,
		.hold_ack_out, .ready_seen, .port_input_force, .p4_pullup, .space_enable, .bclk_out);
	ext_bus_model i_bus (.clk_sys, .rd_n, .bus_addr, .hold_in, .slow, .hold_req, .ready_in);

	// ready as the design saw it at the last edge
	always @(posedge clk_sys)
		rdy_prev <= ready_in;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// sfr, ram, rom, display, external: rom is dropped only in microprocessor mode
	function automatic logic [4:0] exp_space(input logic [1:0] m);
		return (m == 2'h0) ? 5'h0f : ((m == 2'h1) ? 5'h1f : 5'h1b);
	endfunction

	// skip: edges already gone by since the release edge when the task starts
	task automatic run_fetch(input logic micro, input int skip);
		int n;
		int first;
		logic bc;
		logic hbe;
		first = 0;
		hbe = 1'b0;
		i_bus.seen.delete();
		for (n = 1; n < 300 && cpu_run !== 1'b1; n++)
		begin
			@(posedge clk_sys);
			#1;
			if (rd_n === 1'b0 && first == 0)
				first = n + skip;
			if (rd_n === 1'b0)
				hbe = hbe | high_byte_enable;
		end
		check(cpu_run, 1'b1);
		// bus clock runs at half rate once out of reset
		bc = bclk_out;
		@(posedge clk_sys);
		#1;
		check(bclk_out, !bc);
		if (micro)
		begin
			check(first >= 56, 1'b1);
			check(hbe, !byte_pin);
			check(i_bus.seen.size(), byte_pin ? 3 : 2);
			foreach (i_bus.seen[k])
				check(i_bus.seen[k], rst_mode_pkg::VEC_ADDR + (byte_pin ? k : 2 * k));
		end
	endtask

	task automatic hw_reset(input logic mp, input logic bp);
		@(posedge clk_sys);
		mode_select_pin <= mp;
		byte_pin <= bp;
		hold_in <= 1'($random(seed));
		slow <= 1'($random(seed));
		sys_rst <= 1'b1;
		repeat (20) @(posedge clk_sys);
		#1;
		check(cpu_init, 1'b1);
		check(port_input_force[10:6], 5'h1f);
		check(hold_ack_out, mp & hold_req);
		check(ready_seen, mp & rdy_prev);
		if (!mp)
			check(port_input_force, 11'h7ff);
		else
		begin
			check({chip_select_zero, wr_n, rd_n, ale}, 4'he);
			check(p4_pullup, 3'h7);
		end
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		run_fetch(mp, 0);
		check(processor_mode, mp ? rst_mode_pkg::MODE_MICRO : rst_mode_pkg::MODE_SINGLE);
		check(space_enable, exp_space(mp ? 2'h3 : 2'h0));
		check(bus_ctrl_oe, mp);
		check(bus_addr_oe, mp);
	endtask

	initial
	begin
		repeat (3) @(posedge clk_sys);
		hw_reset(1'b0, 1'b0);
		hw_reset(1'b1, 1'b1);
		hw_reset(1'b1, 1'b0);
		exp_m = rst_mode_pkg::MODE_MICRO;
		// forbidden code, expansion, single-chip first; microprocessor last so the watchdog test starts there
		for (int i = 0; i < 16; i++)
		begin
			w = (i < 3) ? 2'(2 - i) : ((i == 15) ? 2'h3 : 2'($random(seed)));
			@(posedge clk_sys);
			mode_wr <= 1'b1;
			mode_wdata <= w;
			@(posedge clk_sys);
			mode_wr <= 1'b0;
			if (w != 2'h2)
				exp_m = w;
			repeat (2) @(posedge clk_sys);
			#1;
			check(processor_mode, exp_m);
			check(space_enable, exp_space(exp_m));
			check(bus_ctrl_oe, exp_m != 2'h0);
		end
		@(posedge clk_sys);
		mode_select_pin <= 1'b0;
		wdt_underflow <= 1'b1;
		@(posedge clk_sys);
		wdt_underflow <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		check(cpu_run, 1'b1);
		@(posedge clk_sys);
		wdt_reset_select <= 1'b1;
		wdt_underflow <= 1'b1;
		@(posedge clk_sys);
		wdt_underflow <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		check(cpu_run, 1'b0);
		run_fetch(1'b1, 3);
		check(processor_mode, rst_mode_pkg::MODE_MICRO);
		conclude();
	end

	// the whole sequence needs well under a thousand cycles
	initial
	begin
		#80000;
		failures++;
		conclude();
	end
endmodule
